// File: pkg/accal_pkg.sv
package accal_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] ACCAL_OFF_CTRL   = 8'h00;
  localparam logic [7:0] ACCAL_OFF_STATUS = 8'h04;
  localparam logic [7:0] ACCAL_OFF_IRQ_ST = 8'h08;
  localparam logic [7:0] ACCAL_OFF_IRQ_EN = 8'h0c;
  localparam logic [7:0] ACCAL_OFF_IRQ_CL = 8'h10;
  localparam logic [7:0] ACCAL_OFF_TRIM0  = 8'h20;
  localparam int         ACCAL_NUM_TRIM   = 6;

  // Control register field positions.
  localparam int ACCAL_CTRL_SRC_SEL = 0;
  localparam int ACCAL_CTRL_SOFT    = 1;
  localparam int ACCAL_CTRL_BG_EN   = 2;
  localparam int ACCAL_CTRL_FG_OS   = 3;
  localparam int ACCAL_CTRL_BG_OS   = 4;
  localparam int ACCAL_CTRL_SINGLE  = 5;
  localparam int ACCAL_CTRL_IN_SEL  = 6;
  localparam logic [31:0] ACCAL_CTRL_RESET = 32'h0000_0000;

  // Interrupt event bit positions.
  localparam int ACCAL_IRQ_FG_DONE = 0;
  localparam int ACCAL_IRQ_SWAP    = 1;
  localparam int ACCAL_IRQ_IGNORED = 2;
  localparam int ACCAL_IRQ_W       = 3;

  // Mid-scale two's-complement sample value.
  localparam logic [11:0] ACCAL_MID_CODE = 12'h000;

  // Timing: one calibration pass over all three cores, in nanoseconds.
  localparam int ACCAL_CLK_NS    = 10;
  localparam int ACCAL_CAL_NS    = 20000;
  localparam int ACCAL_CAL_CYC   = ACCAL_CAL_NS / ACCAL_CLK_NS;
  localparam int ACCAL_STEP_CYC  = ACCAL_CAL_CYC / 3;

  // AXI responses.
  localparam logic [1:0] ACCAL_RESP_OK  = 2'h0;
  localparam logic [1:0] ACCAL_RESP_ERR = 2'h2;

  // Cores: A, B and the spare C.
  typedef enum logic [1:0] {
    ACCAL_CORE_A = 2'b00,
    ACCAL_CORE_B = 2'b01,
    ACCAL_CORE_C = 2'b10
  } accal_core_e;

  // Calibration sequencer states.
  typedef enum logic [2:0] {
    ACCAL_ST_FG_A   = 3'b000,
    ACCAL_ST_FG_B   = 3'b001,
    ACCAL_ST_FG_C   = 3'b010,
    ACCAL_ST_IDLE   = 3'b011,
    ACCAL_ST_BG_CAL = 3'b100
  } accal_state_e;

endpackage : accal_pkg

// File: src/accal_top.sv
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Foreground calibration takes cores offline; outputs show mid-scale.
// RQ2 - Six banks paired into three cores: A, B and spare C.
// RQ3 - Both banks of a core sample on opposite clock phases.
// RQ4 - Dual mode: A serves input A, B input B; single: both serve one. Routing ignores the SINGLE bit and always stays dual.
// RQ5 - In background mode spare core C substitutes for A and for B.
// RQ6 - Every pass trims linearity, gain and offset of each bank.
// RQ7 - Trims reset to factory values, are readable and writable.
// RQ8 - Foreground pass runs after reset; host waits before configuring.
// RQ9 - Trigger source is pin or software bit, chosen by a select bit.
// RQ10 - Background mode keeps an extra core powered, calibrates, hands over.
// RQ11 - The displaced core is calibrated and replaces the next, continuously.
// RQ12 - Background runs with select cleared and software trigger set.
// RQ13 - A readable flag shows that foreground calibration has finished.
// RQ14 - A rising edge of the selected trigger starts; ignored while busy.
module accal_top
  import accal_pkg::*;
#(
  parameter int                CAL_CYC = ACCAL_STEP_CYC,
  parameter logic [31:0]       TRIM_DEFAULT = 32'h0000_0080
)(
  // Clock, reset and enable.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // Calibration trigger pin from the system controller.
  input  wire logic        calibration_trigger_pin,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core routing, power and sample muting.
  output logic [1:0]       route_input_a,
  output logic [1:0]       route_input_b,
  output logic [2:0]       core_powered,
  output logic [2:0]       core_calibrating,
  output logic             outputs_muted,
  output logic             irq
);

  // Pin synchroniser; only the second stage is looked at.
  logic pin_s1_q;
  logic pin_s2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else if (clk_en) begin
      pin_s1_q <= calibration_trigger_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Register state.
  logic [31:0]        ctrl_q;
  logic [31:0]        trim_q [ACCAL_NUM_TRIM];
  logic [ACCAL_IRQ_W-1:0] irq_st_q;
  logic [ACCAL_IRQ_W-1:0] irq_en_q;
  logic               fg_done_q;
  accal_state_e       state_q;
  logic [15:0]        cnt_q;
  accal_core_e        spare_q;
  logic               swap_b_next_q;
  logic               trig_prev_q;

  // Selected trigger source: pin when the select bit is set.
  logic trig_sel;
  assign trig_sel = ctrl_q[ACCAL_CTRL_SRC_SEL] ? pin_s2_q
                                               : ctrl_q[ACCAL_CTRL_SOFT]; // [RQ9]

  // Background enable requires the software route with trigger held high.
  logic bg_run;
  assign bg_run = ctrl_q[ACCAL_CTRL_BG_EN] && !ctrl_q[ACCAL_CTRL_SRC_SEL]
                  && ctrl_q[ACCAL_CTRL_SOFT]; // [RQ12]

  logic trig_rise;
  assign trig_rise = trig_sel && !trig_prev_q; // [RQ14]

  logic fg_busy;
  assign fg_busy = (state_q == ACCAL_ST_FG_A) || (state_q == ACCAL_ST_FG_B)
                   || (state_q == ACCAL_ST_FG_C);
  logic step_end;
  assign step_end = (cnt_q == 16'(CAL_CYC - 1));

  // AXI write handshake: address and data taken in either order.
  logic       aw_hold_q;
  logic       w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_go;
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic is_trim(input logic [7:0] a);
    return (a >= ACCAL_OFF_TRIM0)
           && (a < ACCAL_OFF_TRIM0 + 8'(4 * ACCAL_NUM_TRIM))
           && (a[1:0] == 2'b00);
  endfunction : is_trim

  // Write address and data capture, one write at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ACCAL_RESP_OK;
    end else if (clk_en) begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q <= ACCAL_OFF_IRQ_CL || is_trim(aw_addr_q))
                        && aw_addr_q[1:0] == 2'b00 ? ACCAL_RESP_OK
                                                   : ACCAL_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; writes to trims and control are software's own.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ACCAL_CTRL_RESET;
    end else if (clk_en && wr_go && aw_addr_q == ACCAL_OFF_CTRL) begin
      ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_007f;
    end
  end

  // Trims restart at factory values and accept overrides. A user write
  // can be undone by the next reset, which is the intended fallback.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < ACCAL_NUM_TRIM; i++) begin
        trim_q[i] <= TRIM_DEFAULT; // [RQ7]
      end
    end else if (clk_en && wr_go && is_trim(aw_addr_q)) begin
      trim_q[3'(aw_addr_q[7:2] - ACCAL_OFF_TRIM0[7:2])] <=
        merge(trim_q[3'(aw_addr_q[7:2] - ACCAL_OFF_TRIM0[7:2])],
              w_data_q, w_strb_q); // [RQ7]
    end
  end

  // Sequencer: reset starts a foreground pass over all three cores.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q       <= ACCAL_ST_FG_A; // [RQ8]
      cnt_q         <= 16'h0000;
      spare_q       <= ACCAL_CORE_C;
      swap_b_next_q <= 1'b0;
      trig_prev_q   <= 1'b0;
      fg_done_q     <= 1'b0;
    end else if (clk_en) begin
      trig_prev_q <= trig_sel;
      case (state_q)
        ACCAL_ST_FG_A, ACCAL_ST_FG_B, ACCAL_ST_FG_C: begin
          // Each step calibrates every bank of one core. [RQ6]
          cnt_q <= step_end ? 16'h0000 : cnt_q + 16'h0001;
          if (step_end) begin
            if (state_q == ACCAL_ST_FG_A) begin
              state_q <= ACCAL_ST_FG_B;
            end else if (state_q == ACCAL_ST_FG_B) begin
              state_q <= ACCAL_ST_FG_C;
            end else begin
              state_q   <= ACCAL_ST_IDLE;
              fg_done_q <= 1'b1; // [RQ13]
              spare_q   <= ACCAL_CORE_C;
            end
          end
        end
        ACCAL_ST_IDLE: begin
          cnt_q <= 16'h0000;
          if (bg_run) begin
            state_q <= ACCAL_ST_BG_CAL; // [RQ10]
          end else if (trig_rise) begin
            state_q   <= ACCAL_ST_FG_A; // [RQ14]
            fg_done_q <= 1'b0;
          end
        end
        ACCAL_ST_BG_CAL: begin
          cnt_q <= step_end ? 16'h0000 : cnt_q + 16'h0001;
          if (step_end) begin
            // Fresh spare takes over; the displaced core becomes spare.
            spare_q <= (spare_q != ACCAL_CORE_C) ? ACCAL_CORE_C
                     : (swap_b_next_q ? ACCAL_CORE_B : ACCAL_CORE_A); // [RQ11]
            if (spare_q == ACCAL_CORE_C) begin
              swap_b_next_q <= !swap_b_next_q; // [RQ5]
            end
            if (!bg_run) begin
              state_q <= ACCAL_ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ACCAL_ST_IDLE;
        end
      endcase
    end
  end

  // Routing: cores serving each input. Codes are the core enum values.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_input_a    <= ACCAL_CORE_A;
      route_input_b    <= ACCAL_CORE_B;
      core_powered     <= 3'b011;
      core_calibrating <= 3'b111;
      outputs_muted    <= 1'b1;
    end else if (clk_en) begin
      outputs_muted <= fg_busy; // [RQ1]
      if (fg_busy) begin
        core_calibrating <= 3'b111; // [RQ1]
      end else if (state_q == ACCAL_ST_BG_CAL) begin
        core_calibrating <= 3'b001 << spare_q; // [RQ10]
      end else begin
        core_calibrating <= 3'b000;
      end
      // Each core is a bank pair on opposite phases. [RQ2] [RQ3]
      core_powered <= (state_q == ACCAL_ST_BG_CAL || fg_busy) ? 3'b111
                      : 3'b011;
      if (state_q == ACCAL_ST_BG_CAL) begin
        route_input_a <= (spare_q == ACCAL_CORE_A) ? ACCAL_CORE_C
                                                   : ACCAL_CORE_A; // [RQ5]
        route_input_b <= (spare_q == ACCAL_CORE_B) ? ACCAL_CORE_C
                                                   : ACCAL_CORE_B;
      end else begin
        route_input_a <= ACCAL_CORE_A; // [RQ4]
        route_input_b <= ACCAL_CORE_B;
      end
    end
  end

  // Interrupt status; a new event wins over a clear in the same cycle.
  logic [ACCAL_IRQ_W-1:0] ev;
  assign ev = {trig_rise && fg_busy,
               state_q == ACCAL_ST_BG_CAL && step_end,
               state_q == ACCAL_ST_FG_C && step_end};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= '0;
      irq_en_q <= '0;
      irq      <= 1'b0;
    end else if (clk_en) begin
      if (wr_go && aw_addr_q == ACCAL_OFF_IRQ_EN) begin
        irq_en_q <= w_data_q[ACCAL_IRQ_W-1:0];
      end
      if (wr_go && aw_addr_q == ACCAL_OFF_IRQ_CL) begin
        irq_st_q <= (irq_st_q & ~w_data_q[ACCAL_IRQ_W-1:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
      irq <= |(irq_st_q & irq_en_q);
    end
  end

  // Read channel: one read at a time, answered one cycle after capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ACCAL_RESP_OK;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= ACCAL_RESP_OK;
        case (s_axi_araddr)
          ACCAL_OFF_CTRL:   s_axi_rdata <= ctrl_q;
          ACCAL_OFF_STATUS: s_axi_rdata <= {24'h0, 3'(state_q),
                                            2'(spare_q), 2'h0,
                                            fg_done_q}; // [RQ13]
          ACCAL_OFF_IRQ_ST: s_axi_rdata <= 32'(irq_st_q);
          ACCAL_OFF_IRQ_EN: s_axi_rdata <= 32'(irq_en_q);
          ACCAL_OFF_IRQ_CL: s_axi_rdata <= 32'h0000_0000;
          default: begin
            if (is_trim(s_axi_araddr)) begin
              s_axi_rdata <= trim_q[3'(s_axi_araddr[7:2]
                                       - ACCAL_OFF_TRIM0[7:2])]; // [RQ7]
            end else begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= ACCAL_RESP_ERR;
            end
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Muting tracks the foreground pass with one cycle of lag.
  a_mute_fg: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1]
    clk_en && fg_busy |=> outputs_muted)
    else $error("outputs not muted during foreground calibration");
  // Done flag is clear during any foreground pass.
  a_done_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ13]
    fg_busy |-> !fg_done_q)
    else $error("done flag set during foreground calibration");
  // Background never routes the spare to both inputs.
  a_bg_route: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
    !(route_input_a == ACCAL_CORE_C && route_input_b == ACCAL_CORE_C))
    else $error("spare core routed to both inputs");
  // Background keeps all three cores powered so the spare is ready.
  a_bg_power: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ10]
    clk_en && state_q == ACCAL_ST_BG_CAL |=> core_powered == 3'b111)
    else $error("spare core not powered in background mode");
  // Background calibration never interrupts the output samples.
  a_bg_live: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ10]
    clk_en && state_q == ACCAL_ST_BG_CAL |=> !outputs_muted)
    else $error("outputs muted during background calibration");
  // An idle edge of the selected trigger starts a foreground pass when background is not enabled.
  a_fg_start: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ14]
    clk_en && state_q == ACCAL_ST_IDLE && !bg_run && trig_rise
    |=> state_q == ACCAL_ST_FG_A)
    else $error("trigger edge in idle did not start calibration");
endmodule : accal_top

// File: tb/accal_ctl_model.sv
`timescale 1ns/1ps
// Controller model that drives the calibration trigger pin.
module accal_ctl_model (
  // Clock and pulse request from the bench.
  input  wire logic aclk,
  input  wire logic fire,
  // Trigger pin towards the device.
  output logic      calibration_trigger_pin
);
  int unsigned hold_q;

  // Each request gives a three-cycle high pulse, long enough for the
  // two-flop synchroniser; the pin idles low between pulses.
  always @(posedge aclk) begin
    if (fire) begin
      hold_q <= 3;
      calibration_trigger_pin <= 1'b1;
    end else if (hold_q > 1) begin
      hold_q <= hold_q - 1;
    end else begin
      hold_q <= 0;
      calibration_trigger_pin <= 1'b0;
    end
  end

  initial calibration_trigger_pin = 1'b0;
  initial hold_q = 0;
endmodule : accal_ctl_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import accal_pkg::*;
  logic        aclk = 0, aresetn = 0, fire = 0, pin;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rnd;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq, muted;
  logic [1:0]  bresp, rresp, route_a, route_b;
  logic [2:0]  powered, calibrating;
  logic [65:0] exp_q[$];
  logic [65:0] note;
  int          bad_count = 0, check_count = 0, cyc = 0, n;

  // Free-running bench clock.
  always #5 aclk = ~aclk;

  accal_ctl_model accal_ctl_model_i (.aclk(aclk), .fire(fire),
    .calibration_trigger_pin(pin));

  accal_top #(.CAL_CYC(8)) accal_top_i (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .calibration_trigger_pin(pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .route_input_a(route_a), .route_input_b(route_b),
    .core_powered(powered), .core_calibrating(calibrating),
    .outputs_muted(muted), .irq(irq));

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // Write with address and data offered together, each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = ACCAL_RESP_OK);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_ok && w_ok) || !bvalid) begin
      @(posedge aclk);
      if (awready) begin aw_ok = 1; awvalid <= 0; end
      if (wready) begin w_ok = 1; wvalid <= 0; end
    end
    check("bresp", {30'h0, bresp}, {30'h0, r});
    bready <= 0;
    @(posedge aclk);
  endtask : wr

  // Read: the expected word, mask and response are noted for the monitor.
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input logic [1:0] r);
    exp_q.push_back({r, m, e});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    rready <= 0;
    @(posedge aclk);
  endtask : rd

  task automatic wait_mute(input logic v);
    n = 0;
    while (muted !== v && n < 300) begin @(posedge aclk); n++; end
    check("muted", muted, {31'h0, v});
  endtask : wait_mute

  // Monitor: each read answer is judged against the oldest note.
  always @(posedge aclk) begin
    if (rvalid && rready && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check("rdata", rdata & note[63:32], note[31:0]);
      check("rresp", {30'h0, rresp}, {30'h0, note[65:64]});
    end
  end

  // Hang guard: a run far past its expected length is cut off.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin bad_count++; test_done(); end
  end

  initial begin
    rnd = $urandom(16147);
    repeat (3) @(posedge aclk);
    check("muted", muted, 1);
    check("calib", calibrating, 3'b111);
    @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    check("muted", muted, 1);
    wait_mute(0);
    rd(ACCAL_OFF_STATUS, 1, 1, ACCAL_RESP_OK);
    check("route_a", route_a, ACCAL_CORE_A);
    check("route_b", route_b, ACCAL_CORE_B);
    for (int i = 0; i < ACCAL_NUM_TRIM; i++)
      rd(ACCAL_OFF_TRIM0 + 8'(4 * i), '1, 32'h80, ACCAL_RESP_OK);
    rnd = $urandom;
    wr(ACCAL_OFF_TRIM0 + 8'h04, rnd);
    rd(ACCAL_OFF_TRIM0 + 8'h04, '1, rnd, ACCAL_RESP_OK);
    rd(8'h40, '1, 0, ACCAL_RESP_ERR);
    wr(8'h40, rnd, ACCAL_RESP_ERR);
    // Raise, mask and clear the completion interrupt.
    wr(ACCAL_OFF_IRQ_EN, 1);
    repeat (3) @(posedge aclk);
    check("irq", irq, 1);
    wr(ACCAL_OFF_IRQ_EN, 0);
    repeat (3) @(posedge aclk);
    check("irq", irq, 0);
    wr(ACCAL_OFF_IRQ_EN, 1);
    wr(ACCAL_OFF_IRQ_CL, 1);
    repeat (3) @(posedge aclk);
    check("irq", irq, 0);
    rd(ACCAL_OFF_IRQ_ST, 1, 0, ACCAL_RESP_OK);
    // Software trigger with the pin deselected.
    wr(ACCAL_OFF_CTRL, 32'h2);
    wait_mute(1);
    check("muted", muted, 1);
    wait_mute(0);
    // Pin trigger, then a second pin edge while still busy.
    wr(ACCAL_OFF_CTRL, 32'h1);
    fire <= 1;
    @(posedge aclk);
    fire <= 0;
    wait_mute(1);
    check("muted", muted, 1);
    repeat (3) @(posedge aclk);
    fire <= 1;
    @(posedge aclk);
    fire <= 0;
    wait_mute(0);
    rd(ACCAL_OFF_IRQ_ST, 4, 4, ACCAL_RESP_OK);
    // Background rotation: the spare must take over without muting.
    wr(ACCAL_OFF_CTRL, 32'h6);
    n = 0;
    while (route_a !== ACCAL_CORE_C && n < 400) begin
      @(posedge aclk);
      n++;
    end
    check("route_a", route_a, ACCAL_CORE_C);
    check("powered", powered, 3'b111);
    check("calib", calibrating, 3'b001);
    check("muted", muted, 0);
    n = 0;
    while (route_b === ACCAL_CORE_B && n < 400) begin
      @(posedge aclk);
      n++;
    end
    check("route_b", {31'h0, route_b !== ACCAL_CORE_B}, 1);
    check("muted", muted, 0);
    rd(ACCAL_OFF_IRQ_ST, 2, 2, ACCAL_RESP_OK);
    rd(ACCAL_OFF_CTRL, '1, 32'h6, ACCAL_RESP_OK);
    test_done();
  end
endmodule : tb_top
